// ---- rtl/emb_top.sv ----
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module emb_top
    import emb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [EMB_ABW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EMB_NIN-1:0] gin,
    input wire logic [1:0] blk_clk,
    input wire logic [1:0] blk_ce,
    input wire logic [1:0] blk_clr,
    input wire logic [EMB_AW-1:0] mem_waddr,
    input wire logic [EMB_DW-1:0] mem_wdata,
    input wire logic mem_we,
    input wire logic [EMB_AW-1:0] mem_raddr,
    input wire logic read_strobe,
    input wire logic [EMB_PW-1:0] mem_page,
    output logic [EMB_DW-1:0] glob_out,
    output logic [EMB_NLOC-1:0] loc_out,
    output logic [EMB_DW-1:0] col_o,
    output logic col_oe_n
);
    // ----------------------------------------------------------------
    // Configuration store
    // ----------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [MC_W-1:0] mc_cfg [EMB_NMC];
    logic [EMB_NIN-1:0] gmask [EMB_NPT];
    logic [EMB_NFB-1:0] fmask [EMB_NPT];
    logic [EMB_DW-1:0] ram [EMB_ROWS];
    logic in_mc, in_pt, hit, apb_wr;
    logic [3:0] mc_idx;
    logic [4:0] pt_idx;
    logic [31:0] rd_val;
    logic mode, ckm, oreg, bfall, pgen, drive;
    logic [2:0] asp, k;
    logic [1:0] cinv, clrv, mclr_sel, clk_d;
    logic [EMB_PW-1:0] pgid;
    logic eva, evb, ev_r, mclr, pg_in_ok, wcap;
    logic [EMB_NMC-1:0] mc_q, mc_o, mc_r, mc_ev, mc_clr, mc_nx;
    logic [EMB_NMC:0] chain;
    logic [EMB_NFB-1:0] fb;
    logic [EMB_AW-1:0] waddr_q, raddr_q;
    logic [EMB_DW-1:0] wd_q, rdq, oq, rbits, rrow, memout, next_glob;
    logic [EMB_PW-1:0] pg_q;
    logic wstb, rpend;
    logic [EMB_RW-1:0] row_w, row_r;
    int sh, w, lane_w, lane_r;

    assign in_mc = paddr[EMB_ABW-1:MC_SH] == OFF_MC[EMB_ABW-1:MC_SH];
    assign in_pt = paddr[EMB_ABW-1:PT_SH] == OFF_PT[EMB_ABW-1:PT_SH];
    assign mc_idx = paddr[MC_SH-1:WD_SH];
    assign pt_idx = paddr[PT_SH-1:PT_SEL+1];
    assign apb_wr = psel & penable & pready & pwrite & hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            for (int i = 0; i < EMB_NMC; i++) mc_cfg[i] <= MC_RST;
            for (int i = 0; i < EMB_NPT; i++) begin
                gmask[i] <= '0;
                fmask[i] <= '0;
            end
        end else if (apb_wr) begin
            if (paddr == OFF_CTRL) ctrl <= pwdata[CTRL_W-1:0];
            else if (in_mc) mc_cfg[mc_idx] <= pwdata[MC_W-1:0];
            else if (in_pt && paddr[PT_SEL]) fmask[pt_idx] <= pwdata[EMB_NFB-1:0];
            else if (in_pt) gmask[pt_idx] <= pwdata;
        end
    end

    // ----------------------------------------------------------------
    // APB slave: zero wait states, unmapped or misaligned gives error
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        hit = paddr[WD_SH-1:0] == '0;
        if (paddr == OFF_CTRL) rd_val = 32'(ctrl);
        else if (paddr == OFF_STAT) rd_val = 32'({drive, mc_q});
        else if (in_mc) rd_val = 32'(mc_cfg[mc_idx]);
        else if (in_pt && paddr[PT_SEL]) rd_val = 32'(fmask[pt_idx]);
        else if (in_pt) rd_val = gmask[pt_idx];
        else hit = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & !penable;
            if (psel && !penable) begin
                // Refused reads return zero even when the word lies inside a mapped range
                prdata <= (pwrite || !hit) ? '0 : rd_val;
                pslverr <= !hit;
            end
        end
    end

    // ----------------------------------------------------------------
    // Block clocks and clears
    // ----------------------------------------------------------------
    assign mode = ctrl[F_MODE];
    assign asp = ctrl[F_ASP +: 3];
    assign ckm = ctrl[F_CKM];
    assign oreg = ctrl[F_OREG];
    assign cinv = ctrl[F_CINV +: 2];
    assign bfall = ctrl[F_BFALL];
    assign pgen = ctrl[F_PGEN];
    assign pgid = ctrl[F_PGID +: EMB_PW];
    assign mclr_sel = ctrl[F_MCLR +: 2];

    // Block clocks are sampled as events, so pclk must outrun them twice over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) clk_d <= '0;
        else clk_d <= blk_clk;
    end

    assign eva = blk_clk[0] & !clk_d[0] & blk_ce[0];
    // Second clock takes the opposite edge when mixed polarity is needed
    assign evb = (bfall ? (!blk_clk[1] & clk_d[1]) : (blk_clk[1] & !clk_d[1])) & blk_ce[1];
    assign clrv = blk_clr ^ cinv;
    assign mclr = mclr_sel[1] ? clrv[1] : (mclr_sel[0] & clrv[0]);

    // ----------------------------------------------------------------
    // Macrocells
    // ----------------------------------------------------------------
    assign fb = mc_r[EMB_NFB-1:0];
    assign chain[0] = 1'b0;

    for (genvar m = 0; m < EMB_NMC; m++) begin : g_mc
        logic [MC_W-1:0] c;
        logic t0, t1, own, sum, x, q, nx;
        assign c = mc_cfg[m];
        assign t0 = &(~gmask[2*m] | gin) & &(~fmask[2*m] | fb);
        assign t1 = (&(~gmask[2*m+1] | gin) & &(~fmask[2*m+1] | fb)) ^ c[F_INV];
        assign own = (t0 & !c[F_STR]) | (t1 & !c[F_STR+1]);
        // Each link adds one set of two terms; ripple delay grows per set
        assign chain[m+1] = (t0 & c[F_STR]) | (t1 & c[F_STR+1]) | (c[F_LINK] & chain[m]);
        assign sum = own | (c[F_TAKE] & chain[m]);
        assign x = sum ^ c[F_XOR];
        assign mc_ev[m] = c[F_CKS] ? evb : eva;
        assign mc_clr[m] = c[F_CLR+1] ? clrv[1] : (c[F_CLR] & clrv[0]);
        always_comb begin
            case (emb_rt_t'(c[F_RT +: 2]))
                RT_D: nx = x;
                RT_T: nx = q ^ x;
                RT_JK: nx = (x & !q) | (!t1 & q);
                RT_SR: nx = x | (q & !t1);
                default: nx = x;
            endcase
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) q <= 1'b0;
            else if (mc_clr[m]) q <= 1'b0;
            else if (mc_ev[m]) q <= nx;
        end
        assign mc_nx[m] = nx;
        assign mc_q[m] = q;
        assign mc_o[m] = c[F_BYP] ? x : q;
    end

    // ----------------------------------------------------------------
    // Memory array
    // ----------------------------------------------------------------
    assign k = (asp > ASP_MAX) ? ASP_MAX : asp;
    always_comb begin
        sh = EMB_LG - int'(k);
        w = 1 << sh;
        lane_w = int'(waddr_q) & ((1 << k) - 1);
        lane_r = int'(raddr_q) & ((1 << k) - 1);
    end
    assign row_w = EMB_RW'(waddr_q >> k);
    assign row_r = EMB_RW'(raddr_q >> k);
    assign rrow = ram[row_r];

    always_comb begin
        rbits = '0;
        for (int j = 0; j < EMB_DW; j++) begin
            if (j < w) rbits[j] = rrow[(lane_r << sh) | j];
        end
    end

    // Array has no reset; only its access registers are cleared
    always_ff @(posedge pclk) begin
        if (wstb) begin
            for (int b = 0; b < EMB_DW; b++) begin
                if ((b >> sh) == lane_w) ram[row_w][b] <= wd_q[b & (w - 1)];
            end
        end
    end

    // With pgen set, writes only land in the page this block owns; with pgen clear they land on any page
    assign pg_in_ok = !pgen || mem_page == pgid;
    assign wcap = eva & mem_we & mode & pg_in_ok;

    // Write side always runs on the first block clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waddr_q <= '0;
            wd_q <= '0;
            wstb <= 1'b0;
        end else if (mclr) begin
            waddr_q <= '0;
            wd_q <= '0;
            wstb <= 1'b0;
        end else begin
            wstb <= wcap;
            if (eva) begin
                waddr_q <= mem_waddr;
                wd_q <= mem_wdata;
            end
        end
    end

    // One write and one read port only; a true two-port memory pairs two blocks
    assign ev_r = ckm ? eva : evb;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raddr_q <= '0;
            pg_q <= '0;
            rpend <= 1'b0;
            rdq <= '0;
            oq <= '0;
        end else if (mclr) begin
            raddr_q <= '0;
            pg_q <= '0;
            rpend <= 1'b0;
            rdq <= '0;
            oq <= '0;
        end else begin
            if (ev_r) begin
                raddr_q <= mem_raddr;
                pg_q <= mem_page;
            end
            rpend <= ev_r & read_strobe & mode;
            if (rpend) rdq <= rbits;
            if (evb) oq <= rdq;
        end
    end

    assign memout = oreg ? oq : rdq;
    // With pgen set a block drives only on its own page; with pgen clear it always drives in memory mode
    assign drive = mode & (!pgen | (pg_q == pgid));

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    assign next_glob = mode ? memout : mc_o;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_r <= '0;
            glob_out <= '0;
            loc_out <= '0;
            col_o <= '0;
            col_oe_n <= 1'b1;
        end else begin
            mc_r <= mc_o;
            glob_out <= next_glob;
            loc_out <= {next_glob[EMB_NFB-1], next_glob[EMB_NFB-1:0]};
            col_o <= memout;
            col_oe_n <= !drive;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hold;
        (!mc_ev[0] && !mc_clr[0]) |=> $stable(mc_q[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("macrocell changed without clock event");

    property p_clr;
        mc_clr[0] |=> !mc_q[0];
    endproperty
    a_clr: assert property (p_clr) else $error("cleared macrocell not zero");

    property p_dreg;
        (mc_ev[0] && !mc_clr[0] && mc_cfg[0][F_RT +: 2] == RT_D) |=> mc_q[0] == $past(mc_nx[0]);
    endproperty
    a_dreg: assert property (p_dreg) else $error("D register missed data");

    property p_wstb;
        (wcap && !mclr) |=> wstb && waddr_q == $past(mem_waddr);
    endproperty
    a_wstb: assert property (p_wstb) else $error("write strobe not generated");

    property p_rdata;
        (rpend && !mclr) |=> rdq == $past(rbits);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read register missed data");

    property p_rwclk;
        (!ckm && !evb && !mclr) |=> $stable(raddr_q);
    endproperty
    a_rwclk: assert property (p_rwclk) else $error("read address moved off read clock");

    property p_ioclk;
        (ckm && !eva && !mclr) |=> $stable(raddr_q);
    endproperty
    a_ioclk: assert property (p_ioclk) else $error("read address moved off input clock");

    property p_page;
        (mode && pgen && pg_q != pgid) |=> col_oe_n;
    endproperty
    a_page: assert property (p_page) else $error("driver on for foreign page");

    property p_single;
        (mode && !pgen) |=> !col_oe_n;
    endproperty
    a_single: assert property (p_single) else $error("single block left line floating");

    property p_loc;
        loc_out[EMB_NLOC-1] == loc_out[EMB_NLOC-2];
    endproperty
    a_loc: assert property (p_loc) else $error("duplicate local output differs");

    property p_apb;
        (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("APB ready not one access cycle");

    c_write: cover property (wcap ##1 wstb);
    c_read: cover property (rpend ##1 (oreg && evb));
    c_expand: cover property (chain[EMB_NMC-1] && mc_cfg[EMB_NMC-1][F_TAKE]);
    c_drive: cover property ($fell(col_oe_n));
endmodule : emb_top
`default_nettype wire

// ---- pkg/emb_pkg.sv ----
//----------------------------------------------------------------------
// Contract
//----------------------------------------------------------------------
// Contract
// - Block takes exactly 32 general inputs from adjacent routing.
// - Nine macrocell outputs feed back into the product-term inputs.
// - Product-term mode gives 16 macrocells, two terms and one register each.
// - Each term goes to own OR/XOR or out as expander for a neighbour.
// - One product term per macrocell may be inverted.
// - Register acts as D, T, JK or SR, or is bypassed.
// - Register uses one of two block clocks, gated by that clock's enable.
// - Mixed edge polarity uses both block clocks, one per edge.
// - Two optionally inverted clears; each register picks one or none.
// - OR logic takes up to 32 terms: own two plus 30 borrowed.
// - Expanders chain as up to 15 sets of two terms.
// - Write information is registered; read data output register optional.
// - Dual-port mode reads and writes concurrently on independent clocks.
// - Memory makes its own write strobe from registered request.
// - Ten local outputs, nine distinct, feed adjacent logic.
// - Memory aspect 128x16, 256x8, 512x4, 1024x2 or 2048x1.
// - Wider memories share address and control across parallel blocks.
// - Page decoder enables the column driver only on its own page.
// - Eleven low address bits to array, two bits to page decoder.
// - Page control never double drives nor floats a shared line; here the driver is on in memory mode whenever pgen is clear and off on a foreign page.
// - Clocking is read/write clock or input/output clock.
// - True two-port memory takes two blocks working together.
// - Outputs also drive global row and column routing.
// - Read/write mode: write regs on one clock, read regs on other.
// - Input/output mode: all inputs on one clock, output on other.
package emb_pkg;
    localparam int EMB_NMC = 16;
    localparam int EMB_NIN = 32;
    localparam int EMB_NFB = 9;
    localparam int EMB_NLOC = 10;
    localparam int EMB_NPT = 32;
    localparam int EMB_AW = 11;
    localparam int EMB_DW = 16;
    localparam int EMB_RW = 7;
    localparam int EMB_ROWS = 128;
    localparam int EMB_LG = 4;
    localparam int EMB_PW = 2;
    localparam int EMB_ABW = 12;
    localparam logic [2:0] ASP_MAX = 3'h4;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_MC = 12'h040;
    localparam logic [11:0] OFF_PT = 12'h100;
    localparam int WD_SH = 2;
    localparam int MC_SH = 6;
    localparam int PT_SH = 8;
    localparam int PT_SEL = 2;
    localparam int CTRL_W = 14;
    localparam int MC_W = 12;
    localparam logic [13:0] CTRL_RST = 14'h0;
    localparam logic [11:0] MC_RST = 12'h0;
    // CTRL fields
    localparam int F_MODE = 0;
    localparam int F_ASP = 1;
    localparam int F_CKM = 4;
    localparam int F_OREG = 5;
    localparam int F_CINV = 6;
    localparam int F_BFALL = 8;
    localparam int F_PGEN = 9;
    localparam int F_PGID = 10;
    localparam int F_MCLR = 12;
    // Macrocell config fields
    localparam int F_RT = 0;
    localparam int F_BYP = 2;
    localparam int F_CKS = 3;
    localparam int F_CLR = 4;
    localparam int F_INV = 6;
    localparam int F_STR = 7;
    localparam int F_LINK = 9;
    localparam int F_TAKE = 10;
    localparam int F_XOR = 11;
    typedef enum logic [1:0] {RT_D, RT_T, RT_JK, RT_SR} emb_rt_t;
endpackage : emb_pkg

// ---- dv/emb_le_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module emb_le_model
    import emb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic we_req,
    input wire logic rd_req,
    input wire logic [EMB_AW-1:0] wa_req,
    input wire logic [EMB_AW-1:0] ra_req,
    input wire logic [EMB_DW-1:0] wd_req,
    output logic [1:0] blk_clk,
    output logic mem_we,
    output logic read_strobe,
    output logic [EMB_AW-1:0] mem_waddr,
    output logic [EMB_AW-1:0] mem_raddr,
    output logic [EMB_DW-1:0] mem_wdata
);
    // ------------------------------------------------------------
    // Neighbouring logic elements
    // ------------------------------------------------------------
    // Clocks stand low outside bursts; B is A inverted so reads land between writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_clk <= 2'h0;
        end else begin
            blk_clk <= run ? {blk_clk[0], ~blk_clk[0]} : 2'h0;
        end
    end
    // Request registered on clock A, all the memory asks of its drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_we <= 1'b0;
            read_strobe <= 1'b0;
            mem_waddr <= '0;
            mem_raddr <= '0;
            mem_wdata <= '0;
        end else if (run && !blk_clk[0]) begin
            mem_we <= we_req;
            read_strobe <= rd_req;
            // Idle lines flip, so a stale value can never pass for a request
            mem_waddr <= we_req ? wa_req : ~mem_waddr;
            mem_wdata <= we_req ? wd_req : ~mem_wdata;
            mem_raddr <= rd_req ? ra_req : ~mem_raddr;
        end
    end
endmodule : emb_le_model
`default_nettype wire

// ---- dv/embedded_memory_product_term_block_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module embedded_memory_product_term_block_test
    import emb_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
    logic [EMB_ABW-1:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [EMB_NIN-1:0] gin;
    logic [1:0] blk_clk, blk_ce, blk_clr;
    logic [EMB_AW-1:0] mem_waddr, mem_raddr, wa_req, ra_req;
    logic [EMB_DW-1:0] mem_wdata, wd_req, glob_out, col_o, msk, e;
    logic [EMB_PW-1:0] mem_page;
    logic [EMB_NLOC-1:0] loc_out;
    logic mem_we, read_strobe, col_oe_n, run, we_req, rd_req;
    logic [31:0] m0 [16];
    logic [31:0] m1 [16];
    int fails, checks, cyc, seed, a, k;
    int mdl [int];
    int q [$];

    emb_top u_emb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gin(gin),
        .blk_clk(blk_clk), .blk_ce(blk_ce), .blk_clr(blk_clr), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_raddr(mem_raddr), .read_strobe(read_strobe), .mem_page(mem_page),
        .glob_out(glob_out), .loc_out(loc_out), .col_o(col_o), .col_oe_n(col_oe_n));
    emb_le_model u_emb_le_model (.pclk(pclk), .presetn(presetn), .run(run), .we_req(we_req), .rd_req(rd_req),
        .wa_req(wa_req), .ra_req(ra_req), .wd_req(wd_req), .blk_clk(blk_clk), .mem_we(mem_we),
        .read_strobe(read_strobe), .mem_waddr(mem_waddr), .mem_raddr(mem_raddr), .mem_wdata(mem_wdata));

    // ------------------------------------------------------------
    // Clock, timeout, verdict
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    always @(posedge pclk) begin
        cyc++;
        // The run needs about 1500 cycles; anything far beyond is a hang
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHK(pready, 1'b1)
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [11:0] ad, input logic [31:0] x, input logic xe);
        apb(1'b0, ad, 32'h0);
        `CHK(rdv, x)
        `CHK(erv, xe)
    endtask : rchk
    // Request held over two clock-A periods; a repeat of the same write is harmless
    task automatic mop(input logic w, input int ad, input int d);
        @(posedge pclk);
        we_req <= w;
        rd_req <= ~w;
        wa_req <= EMB_AW'(ad);
        ra_req <= EMB_AW'(ad);
        wd_req <= EMB_DW'(d);
        repeat (4) @(posedge pclk);
        we_req <= 1'b0;
        rd_req <= 1'b0;
        repeat (12) @(posedge pclk);
    endtask : mop
    task automatic mchk(input int ad);
        mop(1'b0, ad, 0);
        e = EMB_DW'(mdl[ad]);
        `CHK(glob_out & msk, e)
        `CHK(col_o & msk, e)
        `CHK(loc_out & {msk[8], msk[8:0]}, {e[8], e[8:0]})
    endtask : mchk
    function automatic logic [15:0] pt(input logic [31:0] g);
        pt = '0;
        for (int m = 0; m < 16; m++) begin
            pt[m] = (&(g | ~m0[m])) | ((&(g | ~m1[m])) ^ m[0]);
        end
    endfunction : pt
    task automatic step(input logic [31:0] g, input logic [1:0] ce, input logic [1:0] cl, input logic x);
        gin <= g;
        blk_ce <= ce;
        blk_clr <= cl;
        run <= 1'b1;
        repeat (8) @(posedge pclk);
        run <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, OFF_STAT, 32'h0);
        `CHK(rdv[0], x)
        `CHK(glob_out[0], x)
    endtask : step

    initial begin
        seed = 32'h3f449813;
        {psel, penable, pwrite, paddr, pwdata, gin, blk_ce, blk_clr, mem_page} = '0;
        {run, we_req, rd_req, wa_req, ra_req, wd_req} = '0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Register widths, read-only status and refused addresses
        rchk(OFF_CTRL, 32'h0, 1'b0);
        apb(1'b1, OFF_CTRL, 32'hffffffff);
        rchk(OFF_CTRL, 32'h3fff, 1'b0);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_STAT, 32'hffffffff);
        rchk(OFF_STAT, 32'h0, 1'b0);
        rchk(OFF_MC, 32'h0, 1'b0);
        apb(1'b1, 12'h008, 32'hffffffff);
        `CHK(erv, 1'b1)
        rchk(12'h008, 32'h0, 1'b1);
        rchk(12'h002, 32'h0, 1'b1);
        // Sparse masks so that terms are true often enough to matter
        for (int m = 0; m < 16; m++) begin
            m0[m] = $random(seed) & $random(seed) & $random(seed);
            m1[m] = $random(seed) & $random(seed) & $random(seed);
            apb(1'b1, 12'(OFF_MC + 4 * m), (1 << F_BYP) | ((m & 1) << F_INV));
            apb(1'b1, 12'(OFF_PT + 16 * m), m0[m]);
            apb(1'b1, 12'(OFF_PT + 16 * m + 8), m1[m]);
        end
        for (int i = 0; i < 40; i++) begin
            gin <= $random(seed);
            repeat (2) @(posedge pclk);
            e = pt(gin);
            `CHK(glob_out, e)
            `CHK(loc_out, {e[8], e[8:0]})
        end
        // Both terms of macrocell 1 lent to macrocell 2, whose output is inverted
        apb(1'b1, OFF_MC + 12'h4, (1 << F_BYP) | (3 << F_STR));
        apb(1'b1, OFF_MC + 12'h8, (1 << F_BYP) | (1 << F_TAKE) | (1 << F_XOR));
        rchk(12'h046, 32'h0, 1'b1);
        repeat (20) begin
            gin <= $random(seed);
            repeat (2) @(posedge pclk);
            `CHK(glob_out[2:1], {~(&(gin | ~m0[2]) | &(gin | ~m1[2]) | &(gin | ~m0[1]) | &(gin | ~m1[1])), 1'b0})
        end
        m0[0] = 32'h1;
        m1[0] = 32'h1;
        apb(1'b1, OFF_MC, 1 << F_CLR);
        apb(1'b1, OFF_PT, 32'h1);
        apb(1'b1, OFF_PT + 12'h8, 32'h1);
        step(32'h1, 2'h3, 2'h0, 1'b1);
        step(32'h0, 2'h2, 2'h0, 1'b1);
        step(32'h1, 2'h3, 2'h1, 1'b0);
        step(32'h1, 2'h3, 2'h0, 1'b1);
        apb(1'b1, OFF_CTRL, 1 << F_CINV);
        step(32'h1, 2'h3, 2'h0, 1'b0);
        blk_ce <= 2'h3;
        blk_clr <= 2'h0;
        run <= 1'b1;
        // Five aspects, then input/output clocking, then the output register
        for (int c = 0; c < 7; c++) begin
            k = (c < 5) ? c : 0;
            msk = EMB_DW'((32'h1 << (16 >> k)) - 1);
            apb(1'b1, OFF_CTRL, 1 | (k << F_ASP) | (int'(c == 5) << F_CKM) | (int'(c == 6) << F_OREG));
            mdl.delete();
            q.delete();
            repeat (4) begin
                // Stay inside the configured depth; higher addresses would alias
                a = $random(seed) & ((EMB_ROWS << k) - 1);
                mdl[a] = $random(seed) & msk;
                q.push_back(a);
                mop(1'b1, a, mdl[a]);
            end
            foreach (q[i]) mchk(q[i]);
        end
        apb(1'b1, OFF_CTRL, 1 | (1 << F_PGEN) | (2 << F_PGID));
        mdl[5] = 16'h1234;
        mem_page <= 2'h2;
        mop(1'b1, 5, 16'h1234);
        mchk(5);
        `CHK(col_oe_n, 1'b0)
        apb(1'b0, OFF_STAT, 32'h0);
        `CHK(rdv[16], 1'b1)
        mem_page <= 2'h1;
        mop(1'b1, 5, 16'h00ef);
        mop(1'b0, 5, 0);
        `CHK(col_oe_n, 1'b1)
        mem_page <= 2'h2;
        mchk(5);
        wrap_up();
    end
endmodule : embedded_memory_product_term_block_test
`default_nettype wire
